// *** logic/nsbtr_core.sv ***
// Notes on behaviour
// - Nibble swap exchanges upper and lower nibbles and keeps all flags.
// - Destination bit 0 writes the working register, 1 the file register.
// - Access bit 0 uses the access bank, 1 uses the bank select register.
// - Access 0, extended set on and address up to 95 use indexed offset.
// - Borrow subtract takes one more when carry clear; carry means no borrow.
// - Borrow subtract sets zero flag exactly when the byte result is zero.
// - Borrow subtract copies result bit 7 into the negative flag.
// - Table read loads latch from program memory; pointer holds, +1 or -1.
// - Table pointer is a 21-bit byte address; bit 0 picks the word half.
`timescale 1ns/1ps
module nsbtr_core
  import nsbtr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic busy_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  nsbtr_state_t state_reg, state_next;
  nsbtr_instr_t instr_reg, new_instr;
  nsbtr_flags_t flags_reg, sub_flags;
  logic [7:0] wreg_reg, table_latch_reg, fval, swap_res, sub_res, op_res;
  logic [3:0] bank_reg;
  logic ext_en_reg, busy_reg, tbl_sel_reg, borrow;
  logic [11:0] index_base_reg, file_addr_reg, eaddr_reg, dmem_raddr;
  logic [20:0] table_pointer_reg, tbl_rdaddr;
  logic [8:0] diff9;
  logic [4:0] nib5;
  logic [15:0] pm_rdata;
  logic dmem_we;
  logic [11:0] dmem_waddr;
  logic [7:0] dmem_wdata;
  logic dp_valid_reg, dp_write_reg, hready_reg, rd_phase_reg;
  logic [7:0] dp_addr_reg, next_addr;
  logic [31:0] hrdata_reg;
  logic acc, dp_end, dp_next_valid, next_write, mem_rd_next;
  logic write_hazard, hready_next, bus_wr, instr_wr, exec_op, is_swap;

  // Operand address resolution for byte-oriented instructions.
  function automatic logic [11:0] nsbtr_eff_addr(input nsbtr_instr_t ins,
      input logic [3:0] bank, input logic ext, input logic [11:0] base);
    if (!ins.access && ext && ins.faddr <= ACCESS_LIMIT) begin
      return 12'(base + {4'h0, ins.faddr});
    end else if (!ins.access) begin
      return (ins.faddr <= ACCESS_LIMIT) ? {4'h0, ins.faddr} :
          {ACCESS_HI_PAGE, ins.faddr};
    end else begin
      return {bank, ins.faddr};
    end
  endfunction : nsbtr_eff_addr

  // Bus read value of every plain register; unmapped offsets read zero.
  function automatic logic [31:0] nsbtr_rd_value(input logic [7:0] ofs,
      input nsbtr_instr_t ins, input logic [7:0] w, input nsbtr_flags_t fl,
      input logic busy, input logic [3:0] bank, input logic ext,
      input logic [11:0] base, input logic [20:0] ptr, input logic [7:0] lat,
      input logic [11:0] fa);
    case (ofs)
      OFS_INSTR: return {16'h0000, ins};
      OFS_WORK: return {24'h000000, w};
      OFS_FLAGS: return {23'h000000, busy, 3'h0, fl};
      OFS_BANK: return {28'h0000000, bank};
      OFS_CONFIG: return {31'h00000000, ext};
      OFS_INDEX_BASE: return {20'h00000, base};
      OFS_TBL_PTR: return {11'h000, ptr};
      OFS_TBL_LATCH: return {24'h000000, lat};
      OFS_FILE_ADDR: return {20'h00000, fa};
      default: return RST_WORD;
    endcase
  endfunction : nsbtr_rd_value

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Any data phase stalls while an instruction runs, so bus writes never
  // collide with execution; the price is a few wait states.
  assign acc = hsel_i & htrans_i[1] & hready_i;
  assign dp_end = dp_valid_reg & hready_reg;
  assign dp_next_valid = acc | (dp_valid_reg & ~hready_reg);
  assign next_addr = acc ? haddr_i[7:0] : dp_addr_reg;
  assign next_write = acc ? hwrite_i : dp_write_reg;
  assign mem_rd_next = dp_next_valid & ~next_write &
      (next_addr == OFS_FILE_DATA);
  assign write_hazard = dp_end & dp_write_reg;
  assign hready_next = ~dp_next_valid | (~busy_reg & (state_next == ST_IDLE)
      & ~write_hazard & (~mem_rd_next | rd_phase_reg));
  assign bus_wr = dp_end & dp_write_reg;
  assign new_instr = nsbtr_instr_t'(hwdata_i[15:0]);
  assign instr_wr = bus_wr & (dp_addr_reg == OFS_INSTR) &
      (state_reg == ST_IDLE);

  // Data phase tracking; hsize is accepted as is, only words are expected.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= RST_BYTE;
      hready_reg <= 1'b1;
    end else begin
      dp_valid_reg <= dp_next_valid;
      dp_write_reg <= next_write;
      dp_addr_reg <= next_addr;
      hready_reg <= hready_next;
    end
  end

  // File window reads take one edge to issue and one to capture.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_phase_reg <= 1'b0;
      hrdata_reg <= RST_WORD;
    end else begin
      if (hready_next) begin
        rd_phase_reg <= 1'b0;
      end else if (dp_valid_reg && !hready_reg && mem_rd_next &&
          state_reg == ST_IDLE) begin
        rd_phase_reg <= 1'b1;
      end
      if (hready_next && dp_next_valid && !next_write) begin
        hrdata_reg <= mem_rd_next ? {24'h000000, fval} :
            nsbtr_rd_value(next_addr, instr_reg, wreg_reg, flags_reg,
            busy_reg, bank_reg, ext_en_reg, index_base_reg, table_pointer_reg,
            table_latch_reg, file_addr_reg);
      end
    end
  end

  // Plain configuration registers written by software.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      bank_reg <= RST_BANK;
      ext_en_reg <= 1'b0;
      index_base_reg <= RST_FILE_ADDR;
      file_addr_reg <= RST_FILE_ADDR;
    end else if (bus_wr) begin
      case (dp_addr_reg)
        OFS_BANK: bank_reg <= hwdata_i[3:0];
        OFS_CONFIG: ext_en_reg <= hwdata_i[0];
        OFS_INDEX_BASE: index_base_reg <= hwdata_i[11:0];
        OFS_FILE_ADDR: file_addr_reg <= hwdata_i[11:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Instruction sequencer
  // ****************************************************************
  // Unknown opcodes are dropped and leave the sequencer idle.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (instr_wr) begin
          if (new_instr.opcode == OP_NIBBLE_SWAP ||
              new_instr.opcode == OP_SUB_BORROW) begin
            state_next = ST_READ;
          end else if (hwdata_i[15:2] == TBL_READ_PREFIX) begin
            state_next = ST_TBL_ADDR;
          end
        end
      end
      ST_READ: state_next = ST_EXEC;
      ST_EXEC: state_next = ST_IDLE;
      ST_TBL_ADDR: state_next = ST_TBL_LATCH;
      ST_TBL_LATCH: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // State, busy flag and the captured instruction word.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      instr_reg <= nsbtr_instr_t'(RST_INSTR);
    end else begin
      state_reg <= state_next;
      busy_reg <= (state_next != ST_IDLE);
      if (instr_wr) begin
        instr_reg <= new_instr;
      end
    end
  end

  // ****************************************************************
  // Byte datapath
  // ****************************************************************
  assign dmem_raddr = (state_reg == ST_READ) ? nsbtr_eff_addr(instr_reg,
      bank_reg, ext_en_reg, index_base_reg) : file_addr_reg;
  assign is_swap = (instr_reg.opcode == OP_NIBBLE_SWAP);
  assign exec_op = (state_reg == ST_EXEC);
  assign swap_res = {fval[3:0], fval[7:4]};
  assign borrow = ~flags_reg.carry;
  assign diff9 = {1'b0, fval} - {1'b0, wreg_reg} - {8'h00, borrow};
  assign nib5 = {1'b0, fval[3:0]} - {1'b0, wreg_reg[3:0]} - {4'h0, borrow};
  assign sub_res = diff9[7:0];
  assign sub_flags.carry = ~diff9[8];
  assign sub_flags.dcarry = ~nib5[4];
  assign sub_flags.zero = (sub_res == 8'h00);
  assign sub_flags.ovf = (fval[7] != wreg_reg[7]) && (sub_res[7] != fval[7]);
  assign sub_flags.neg = sub_res[7];
  assign op_res = is_swap ? swap_res : sub_res;

  // Hold the operand address for write-back.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      eaddr_reg <= RST_FILE_ADDR;
    end else if (state_reg == ST_READ) begin
      eaddr_reg <= dmem_raddr;
    end
  end

  // File write port: execution owns it in the execute state, software otherwise.
  assign dmem_we = exec_op ? (instr_reg.dest != DEST_WORK) :
      (bus_wr && dp_addr_reg == OFS_FILE_DATA);
  assign dmem_waddr = exec_op ? eaddr_reg : file_addr_reg;
  assign dmem_wdata = exec_op ? op_res : hwdata_i[7:0];

  // Working register: result goes here when the destination bit is clear.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wreg_reg <= RST_BYTE;
    end else if (exec_op && instr_reg.dest == DEST_WORK) begin
      wreg_reg <= op_res;
    end else if (bus_wr && dp_addr_reg == OFS_WORK) begin
      wreg_reg <= hwdata_i[7:0];
    end
  end

  // Status flags; the swap leaves them alone.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      flags_reg <= '0;
    end else if (exec_op && !is_swap) begin
      flags_reg <= sub_flags;
    end else if (bus_wr && dp_addr_reg == OFS_FLAGS) begin
      flags_reg <= nsbtr_flags_t'(hwdata_i[4:0]);
    end
  end

  nsbtr_mem #(
    .AW(FILE_AW),
    .DW(8)
  ) u_file_mem (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .we_i(dmem_we),
    .waddr_i(dmem_waddr),
    .wdata_i(dmem_wdata),
    .raddr_i(dmem_raddr),
    .rdata_o(fval)
  );

  // ****************************************************************
  // Table read path
  // ****************************************************************
  // Only the low pointer bits reach the small program store; upper bits
  // wrap onto it.
  assign tbl_rdaddr = (instr_reg.faddr[1:0] == TBL_MODE_PRE_INC) ?
      21'(table_pointer_reg + 21'h000001) : table_pointer_reg;

  // Pointer updates for each addressing form, and software loads.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      table_pointer_reg <= RST_TBL_PTR;
      tbl_sel_reg <= 1'b0;
    end else if (state_reg == ST_TBL_ADDR) begin
      tbl_sel_reg <= tbl_rdaddr[0];
      table_pointer_reg <= tbl_rdaddr;
    end else if (state_reg == ST_TBL_LATCH) begin
      case (instr_reg.faddr[1:0])
        TBL_MODE_POST_INC: table_pointer_reg <= 21'(table_pointer_reg + 21'h000001);
        TBL_MODE_POST_DEC: table_pointer_reg <= 21'(table_pointer_reg - 21'h000001);
        default: table_pointer_reg <= table_pointer_reg;
      endcase
    end else if (bus_wr && dp_addr_reg == OFS_TBL_PTR) begin
      table_pointer_reg <= hwdata_i[20:0];
    end
  end

  // Latch picks the low byte for an even pointer, the high byte for odd.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      table_latch_reg <= RST_BYTE;
    end else if (state_reg == ST_TBL_LATCH) begin
      table_latch_reg <= tbl_sel_reg ? pm_rdata[15:8] : pm_rdata[7:0];
    end
  end

  nsbtr_mem #(
    .AW(PM_WAW),
    .DW(PM_DW)
  ) u_prog_mem (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .we_i(bus_wr && dp_addr_reg == OFS_PROG_DATA),
    .waddr_i(table_pointer_reg[PM_WAW:1]),
    .wdata_i(hwdata_i[15:0]),
    .raddr_i(tbl_rdaddr[PM_WAW:1]),
    .rdata_o(pm_rdata)
  );

  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = hready_reg;
  assign hresp_o = 1'b0;
  assign busy_o = busy_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_swap_work;
    exec_op && is_swap && !instr_reg.dest |=>
        wreg_reg == {$past(fval[3:0]), $past(fval[7:4])};
  endproperty
  a_swap_work: assert property (p_swap_work)
    else $error("swap result wrong");

  property p_swap_flags;
    exec_op && is_swap |=> $stable(flags_reg);
  endproperty
  a_swap_flags: assert property (p_swap_flags)
    else $error("swap changed flags");

  property p_dest_file;
    exec_op && instr_reg.dest |-> dmem_we ##1 $stable(wreg_reg);
  endproperty
  a_dest_file: assert property (p_dest_file)
    else $error("file destination not honoured");

  property p_bank;
    state_reg == ST_READ && instr_reg.access |->
        dmem_raddr == {bank_reg, instr_reg.faddr};
  endproperty
  a_bank: assert property (p_bank)
    else $error("banked address wrong");

  property p_indexed;
    state_reg == ST_READ && !instr_reg.access && ext_en_reg &&
        instr_reg.faddr <= 8'h5f |->
        dmem_raddr == 12'(index_base_reg + {4'h0, instr_reg.faddr});
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed offset address wrong");

  property p_carry;
    exec_op && !is_swap |=> flags_reg.carry == ({1'b0, $past(fval)} >=
        9'({1'b0, $past(wreg_reg)} + {8'h00, ~$past(flags_reg.carry)}));
  endproperty
  a_carry: assert property (p_carry)
    else $error("borrow carry wrong");

  property p_zero;
    exec_op && !is_swap |=> flags_reg.zero ==
        (8'($past(fval) - $past(wreg_reg) - {7'h00, ~$past(flags_reg.carry)})
        == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

  property p_neg;
    exec_op && !is_swap && instr_reg.dest == DEST_WORK |=>
        flags_reg.neg == wreg_reg[7];
  endproperty
  a_neg: assert property (p_neg)
    else $error("negative flag wrong");

  property p_tbl_inc;
    state_reg == ST_TBL_ADDR && instr_reg.faddr[1:0] == TBL_MODE_POST_INC
        |=> ##1 table_pointer_reg == 21'($past(table_pointer_reg, 2) + 21'h000001);
  endproperty
  a_tbl_inc: assert property (p_tbl_inc)
    else $error("post increment wrong");

  property p_tbl_byte;
    state_reg == ST_TBL_ADDR && !tbl_rdaddr[0] |=>
        ##1 table_latch_reg == $past(pm_rdata[7:0]);
  endproperty
  a_tbl_byte: assert property (p_tbl_byte)
    else $error("table latch byte wrong");

  property p_decode;
    instr_wr && new_instr.opcode == OP_SUB_BORROW |=>
        state_reg == ST_READ ##1 state_reg == ST_EXEC ##1 state_reg == ST_IDLE;
  endproperty
  a_decode: assert property (p_decode)
    else $error("byte instruction sequence wrong");

endmodule : nsbtr_core

// *** logic/nsbtr_pkg.sv ***
package nsbtr_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned FILE_AW = 12;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned TP_W = 21;
  localparam int unsigned PM_WAW = 9;
  localparam int unsigned PM_DW = 16;

  // ****************************************************************
  // Register byte offsets on the bus
  // ****************************************************************
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_WORK = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0c;
  localparam logic [7:0] OFS_CONFIG = 8'h10;
  localparam logic [7:0] OFS_INDEX_BASE = 8'h14;
  localparam logic [7:0] OFS_TBL_PTR = 8'h18;
  localparam logic [7:0] OFS_TBL_LATCH = 8'h1c;
  localparam logic [7:0] OFS_FILE_ADDR = 8'h20;
  localparam logic [7:0] OFS_FILE_DATA = 8'h24;
  localparam logic [7:0] OFS_PROG_DATA = 8'h28;

  // ****************************************************************
  // Decode values and addressing constants
  // ****************************************************************
  localparam logic [5:0] OP_NIBBLE_SWAP = 6'h0e;
  localparam logic [5:0] OP_SUB_BORROW = 6'h16;
  localparam logic [13:0] TBL_READ_PREFIX = 14'h0002;
  localparam logic [1:0] TBL_MODE_HOLD = 2'h0;
  localparam logic [1:0] TBL_MODE_POST_INC = 2'h1;
  localparam logic [1:0] TBL_MODE_POST_DEC = 2'h2;
  localparam logic [1:0] TBL_MODE_PRE_INC = 2'h3;
  localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_HI_PAGE = 4'hf;
  localparam logic DEST_WORK = 1'b0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_FILE_ADDR = 12'h000;
  localparam logic [20:0] RST_TBL_PTR = 21'h000000;
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [5:0] opcode;
    logic dest;
    logic access;
    logic [7:0] faddr;
  } nsbtr_instr_t;

  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic dcarry;
    logic carry;
  } nsbtr_flags_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_EXEC = 3'b010,
    ST_TBL_ADDR = 3'b011,
    ST_TBL_LATCH = 3'b100
  } nsbtr_state_t;

endpackage : nsbtr_pkg

// *** logic/nsbtr_mem.sv ***
`timescale 1ns/1ps
module nsbtr_mem #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [DW-1:0] mem_reg [0:(1<<AW)-1];
  logic [DW-1:0] rdata_reg;

  // Array contents are not reset; only the read register is.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // Registered read: data appear one edge after the address.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= mem_reg[raddr_i];
    end
  end

  assign rdata_o = rdata_reg;

endmodule : nsbtr_mem

// *** testbench/nsbtr_tb.sv ***
`timescale 1ns/1ps
module testbench;
  import nsbtr_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic busy;
  logic [31:0] rd;
  int fail_count = 0;
  int checked = 0;

  // ****************************************************************
  // Clock and design
  // ****************************************************************
  always #5 clk_i = ~clk_i;

  nsbtr_core uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .busy_o(busy));

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  // Compares one design pin with its expected level.
  task automatic chk_pin(input logic got, input logic exp, input string n);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t pin %s got %b exp %b", $time, n, got, exp);
    end
  endtask : chk_pin

  // One single word transfer; waits have no bound of their own, the
  // watchdog is what ends a stalled slave.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h00000000;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    q = hrdata;
    chk_pin(hresp, 1'b0, "hresp");
  endtask : xfer

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : bus_wr

  // Reads a register and compares the masked value.
  task automatic chk(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    xfer(1'b0, a, 32'h00000000, rd);
    checked++;
    if ((rd & m) !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t addr %h got %h exp %h", $time, a, rd & m, e);
    end
  endtask : chk

  task automatic put(input logic [11:0] fa, input logic [7:0] v);
    bus_wr(OFS_FILE_ADDR, {20'h00000, fa});
    bus_wr(OFS_FILE_DATA, {24'h000000, v});
  endtask : put

  task automatic file_chk(input logic [11:0] fa, input logic [7:0] v);
    bus_wr(OFS_FILE_ADDR, {20'h00000, fa});
    chk(OFS_FILE_DATA, {24'h000000, v}, 32'h000000ff);
  endtask : file_chk

  function automatic logic [31:0] ins(input logic [5:0] op, input logic d,
                                      input logic a, input logic [7:0] f);
    return {16'h0000, op, d, a, f};
  endfunction : ins

  task automatic wrap_up();
    $display("Counts: %0d checked, %0d failed", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  // The whole sequence needs a few hundred cycles; this is ample.
  initial begin
    #200us;
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    wrap_up();
  end

  // ****************************************************************
  // Scenario tables
  // ****************************************************************
  // Addressing cases: bank, extended set, access bit, operand, location.
  logic [3:0] bk [6] = '{4'h2, 4'h0, 4'h0, 4'h0, 4'h5, 4'h0};
  logic ex [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  logic ac [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [7:0] fo [6] = '{8'h45, 8'h70, 8'h5f, 8'h60, 8'h10, 8'h20};
  logic [11:0] ph [6] = '{12'h245, 12'hf70, 12'h35f, 12'hf60, 12'h510,
                          12'h020};
  // Borrow subtract cases: f, W, carry in, dest, result, {N,Z,C}.
  logic [7:0] sf [3] = '{8'h19, 8'h1b, 8'h03};
  logic [7:0] sw [3] = '{8'h0d, 8'h1a, 8'h0e};
  logic sc [3] = '{1'b1, 1'b0, 1'b1};
  logic sd [3] = '{1'b1, 1'b0, 1'b1};
  logic [7:0] sr [3] = '{8'h0c, 8'h00, 8'hf5};
  logic [2:0] sfl [3] = '{3'b001, 3'b011, 3'b100};
  // Table read cases: start pointer, mode, latch, final pointer.
  logic [20:0] tp [5] = '{21'h0a356, 21'h0a357, 21'h0a357, 21'h0a357,
                          21'h1fffff};
  logic [1:0] tm [5] = '{TBL_MODE_POST_INC, TBL_MODE_HOLD,
                         TBL_MODE_POST_DEC, TBL_MODE_PRE_INC,
                         TBL_MODE_POST_INC};
  logic [7:0] tl [5] = '{8'h34, 8'h12, 8'h12, 8'h78, 8'h9a};
  logic [20:0] te [5] = '{21'h0a357, 21'h0a357, 21'h0a356, 21'h0a358,
                          21'h000000};

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    chk(OFS_WORK, 32'h00000000, 32'hffffffff);
    chk(OFS_FLAGS, 32'h00000000, 32'hffffffff);
    chk(OFS_TBL_PTR, 32'h00000000, 32'hffffffff);
    $display("Test reset done");

    // Swap writes back, keeps all flags, then swaps into W.
    for (int i = 0; i < 6; i++) begin
      bus_wr(OFS_BANK, {28'h0000000, bk[i]});
      bus_wr(OFS_CONFIG, {31'h00000000, ex[i]});
      bus_wr(OFS_INDEX_BASE, 32'h00000300);
      put(ph[i], 8'h53 + 8'(i));
      bus_wr(OFS_FLAGS, 32'h0000001f);
      bus_wr(OFS_INSTR, ins(OP_NIBBLE_SWAP, 1'b1, ac[i], fo[i]));
      @(posedge clk_i);
      chk_pin(busy, 1'b1, "busy");
      file_chk(ph[i], {4'h3 + 4'(i), 4'h5});
      chk(OFS_FLAGS, 32'h0000001f, 32'h000001ff);
      bus_wr(OFS_INSTR, ins(OP_NIBBLE_SWAP, DEST_WORK, ac[i], fo[i]));
      chk(OFS_WORK, 32'h00000053 + i, 32'hffffffff);
    end
    $display("Test swap and addressing done");

    // Borrow subtract on the three worked cases.
    bus_wr(OFS_BANK, 32'h00000002);
    for (int i = 0; i < 3; i++) begin
      put(12'h245, sf[i]);
      bus_wr(OFS_WORK, {24'h000000, sw[i]});
      bus_wr(OFS_FLAGS, {31'h00000000, sc[i]});
      bus_wr(OFS_INSTR, ins(OP_SUB_BORROW, sd[i], 1'b1, 8'h45));
      if (sd[i]) begin
        file_chk(12'h245, sr[i]);
        chk(OFS_WORK, {24'h000000, sw[i]}, 32'hffffffff);
      end else begin
        chk(OFS_WORK, {24'h000000, sr[i]}, 32'hffffffff);
        file_chk(12'h245, sf[i]);
      end
      chk(OFS_FLAGS, {27'h0, sfl[i][2], 1'b0, sfl[i][1], 1'b0, sfl[i][0]},
          32'h00000015);
    end
    $display("Test borrow subtract done");

    // Table reads in all four pointer modes, and the 21-bit wrap.
    bus_wr(OFS_TBL_PTR, 32'h0000a356);
    bus_wr(OFS_PROG_DATA, 32'h00001234);
    bus_wr(OFS_TBL_PTR, 32'h0000a358);
    bus_wr(OFS_PROG_DATA, 32'h00005678);
    bus_wr(OFS_TBL_PTR, 32'h001fffff);
    bus_wr(OFS_PROG_DATA, 32'h00009abc);
    for (int i = 0; i < 5; i++) begin
      bus_wr(OFS_TBL_PTR, {11'h000, tp[i]});
      bus_wr(OFS_INSTR, {16'h0000, TBL_READ_PREFIX, tm[i]});
      @(posedge clk_i);
      chk_pin(busy, 1'b1, "busy");
      chk(OFS_TBL_LATCH, {24'h000000, tl[i]}, 32'hffffffff);
      chk(OFS_TBL_PTR, {11'h000, te[i]}, 32'hffffffff);
    end
    // An unknown opcode is dropped: no busy period and W keeps its value.
    bus_wr(OFS_INSTR, 32'h0000ffff);
    @(posedge clk_i);
    chk_pin(busy, 1'b0, "busy");
    chk(OFS_WORK, 32'h0000000e, 32'hffffffff);
    // The latch is read only and an unmapped word reads zero.
    bus_wr(OFS_TBL_LATCH, 32'h000000ff);
    chk(OFS_TBL_LATCH, 32'h0000009a, 32'hffffffff);
    bus_wr(8'h3c, 32'hffffffff);
    chk(8'h3c, 32'h00000000, 32'hffffffff);
    $display("Test table read done");
    wrap_up();
  end
endmodule : testbench
